/* File: logic/tracking_id_gain_regs.sv */
// register block: channel 3 fast tracking, identity codes and gain lookup
//
// Functional notes
// - channel 3 tracking factor, bits 1:0, resets 01
// - factor applied only while channel 3 output negative
// - read-only 16-bit maker and part codes
// - gain code multiples of eight give powers of two
// - group codes add B/16 then B/8 each
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module tracking_id_gain_regs #(
    parameter int          DATA_W         = 16,
    parameter bit          FOUR_CHANNEL   = 1'b1,
    parameter logic [15:0] MAKER_CODE     = 16'ha5c3, // arbitrary value
    parameter logic [7:0]  PART_LOW_2CH   = 8'h3c,    // arbitrary value
    parameter logic [7:0]  PART_LOW_4CH   = 8'h3d,    // arbitrary value
    parameter logic [7:0]  PART_HIGH      = 8'h7e     // arbitrary value
) (
    input  wire logic                                aclk,
    input  wire logic                                aresetn,
    // axi4-lite slave
    input  wire logic                                s_axi_awvalid,
    output var  logic                                s_axi_awready,
    input  wire logic [tracking_id_gain_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                          s_axi_awprot,
    input  wire logic                                s_axi_wvalid,
    output var  logic                                s_axi_wready,
    input  wire logic [31:0]                         s_axi_wdata,
    input  wire logic [3:0]                          s_axi_wstrb,
    output var  logic                                s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    output var  logic [1:0]                          s_axi_bresp,
    input  wire logic                                s_axi_arvalid,
    output var  logic                                s_axi_arready,
    input  wire logic [tracking_id_gain_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                          s_axi_arprot,
    output var  logic                                s_axi_rvalid,
    input  wire logic                                s_axi_rready,
    output var  logic [31:0]                         s_axi_rdata,
    output var  logic [1:0]                          s_axi_rresp,
    // core side
    input  wire logic signed [DATA_W-1:0]            ch3_processed_output,
    input  wire tracking_id_gain_pkg::gain_code_t    gain_code
                                  [tracking_id_gain_pkg::NUM_CHANNELS],
    output var  tracking_id_gain_pkg::gain_factor_t  gain_factor
                                  [tracking_id_gain_pkg::NUM_CHANNELS],
    output var  tracking_id_gain_pkg::track_ctl_t    ch3_track_ctl
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic                                       aw_held;
    logic                                       w_held;
    logic [7:0]                                 aw_idx;
    logic [31:0]                                w_data;
    logic [3:0]                                 w_strb;
    logic                                       do_write;
    logic                                       next_aw_held;
    logic                                       next_w_held;
    logic                                       next_bvalid;
    logic                                       next_rvalid;
    logic                                       ar_take;
    logic [7:0]                                 ar_idx;
    logic [tracking_id_gain_pkg::FTF_W-1:0]     ch3_fast_track_factor;
    logic [15:0]                                part_code;
    logic [31:0]                                read_word;
    logic                                       read_hit;

    // identity value depends on the channel-count variant
    assign part_code = {PART_HIGH,
                        FOUR_CHANNEL ? PART_LOW_4CH : PART_LOW_2CH};

    // ------------------------------------------------------------
    // write channel handshakes
    // ------------------------------------------------------------
    // a write fires once address and data are both held and no
    // response is still pending
    always_comb begin
        do_write     = aw_held && w_held && !s_axi_bvalid;
        next_aw_held = (aw_held && !do_write)
                       || (s_axi_awvalid && s_axi_awready);
        next_w_held  = (w_held && !do_write)
                       || (s_axi_wvalid && s_axi_wready);
        if (do_write) begin
            next_bvalid = 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end else begin
            next_bvalid = s_axi_bvalid;
        end
    end

    // address and data holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_idx        <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_idx <= s_axi_awaddr[tracking_id_gain_pkg::IDX_LSB +: 8];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // write response; unmapped indices answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= tracking_id_gain_pkg::RESP_OKAY;
        end else begin
            s_axi_bvalid <= next_bvalid;
            if (do_write) begin
                unique case (aw_idx)
                    tracking_id_gain_pkg::IDX_CH3_FAST_TRACKING,
                    tracking_id_gain_pkg::IDX_MAKER_CODE_LOW,
                    tracking_id_gain_pkg::IDX_MAKER_CODE_HIGH,
                    tracking_id_gain_pkg::IDX_PART_CODE_LOW,
                    tracking_id_gain_pkg::IDX_PART_CODE_HIGH: begin
                        s_axi_bresp <= tracking_id_gain_pkg::RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= tracking_id_gain_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // tracking factor register
    // ------------------------------------------------------------
    // only byte lane 0 carries the field; reserved bits are not kept,
    // identity indices have no storage so writes to them vanish
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch3_fast_track_factor <= tracking_id_gain_pkg::FTF_RESET;
        end else if (do_write && w_strb[0]
                     && aw_idx == tracking_id_gain_pkg::IDX_CH3_FAST_TRACKING)
        begin
            ch3_fast_track_factor <=
                w_data[tracking_id_gain_pkg::FTF_LSB +:
                       tracking_id_gain_pkg::FTF_W];
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    // read data mux; reserved and unused bits read as zero
    always_comb begin
        ar_idx    = s_axi_araddr[tracking_id_gain_pkg::IDX_LSB +: 8];
        read_word = 32'h0000_0000;
        read_hit  = 1'b1;
        unique case (ar_idx)
            tracking_id_gain_pkg::IDX_CH3_FAST_TRACKING: begin
                read_word[tracking_id_gain_pkg::FTF_LSB +:
                          tracking_id_gain_pkg::FTF_W] = ch3_fast_track_factor;
            end
            tracking_id_gain_pkg::IDX_MAKER_CODE_LOW: begin
                read_word[7:0] = MAKER_CODE[7:0];
            end
            tracking_id_gain_pkg::IDX_MAKER_CODE_HIGH: begin
                read_word[7:0] = MAKER_CODE[15:8];
            end
            tracking_id_gain_pkg::IDX_PART_CODE_LOW: begin
                read_word[7:0] = part_code[7:0];
            end
            tracking_id_gain_pkg::IDX_PART_CODE_HIGH: begin
                read_word[7:0] = part_code[15:8];
            end
            default: begin
                read_hit = 1'b0;
            end
        endcase
        ar_take = s_axi_arvalid && s_axi_arready;
        if (ar_take) begin
            next_rvalid = 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end else begin
            next_rvalid = s_axi_rvalid;
        end
    end

    // read response, answered one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= tracking_id_gain_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= read_word;
                s_axi_rresp <= read_hit ? tracking_id_gain_pkg::RESP_OKAY
                                        : tracking_id_gain_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // baseline tracking control for channel 3
    // ------------------------------------------------------------
    // factor passed on only while the processed output is negative
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch3_track_ctl <= '0;
        end else begin
            ch3_track_ctl.active <= ch3_processed_output[DATA_W-1];
            ch3_track_ctl.factor <= ch3_processed_output[DATA_W-1]
                                    ? ch3_fast_track_factor
                                    : '0;
        end
    end

    // ------------------------------------------------------------
    // gain code to normalized factor, one lookup per channel
    // ------------------------------------------------------------
    // upper bits pick the power of two B, lower bits the step;
    // step m>0 gives B*(16+2m-1)/16, so no multiplier is needed
    for (genvar ch = 0; ch < tracking_id_gain_pkg::NUM_CHANNELS; ch++) begin
        : g_gain
        logic [2:0]  exp_sel;
        logic [2:0]  mant;
        logic [11:0] base_sixteenths;

        assign exp_sel = gain_code[ch][5:3];
        assign mant    = gain_code[ch][2:0];
        assign base_sixteenths = (mant == 3'h0)
            ? tracking_id_gain_pkg::GAIN_UNITY
            : tracking_id_gain_pkg::GAIN_UNITY
              + {7'h00, mant, 1'b0} - 12'h001;

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                gain_factor[ch] <= tracking_id_gain_pkg::GAIN_UNITY;
            end else begin
                gain_factor[ch] <= base_sixteenths << exp_sel;
            end
        end
    end

endmodule

`default_nettype wire

/* File: shared/tracking_id_gain_pkg.sv */
// constants and types for the tracking, identity and gain register block
package tracking_id_gain_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CH3_FAST_TRACKING = 8'h2b;
    localparam logic [7:0] IDX_MAKER_CODE_LOW    = 8'hfc;
    localparam logic [7:0] IDX_MAKER_CODE_HIGH   = 8'hfd;
    localparam logic [7:0] IDX_PART_CODE_LOW     = 8'hfe;
    localparam logic [7:0] IDX_PART_CODE_HIGH    = 8'hff;
    localparam int         ADDR_W                = 10;
    localparam int         IDX_LSB               = 2;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int         FTF_LSB               = 0;
    localparam int         FTF_W                 = 2;
    localparam logic [1:0] FTF_RESET             = 2'h1;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY             = 2'h0;
    localparam logic [1:0] RESP_SLVERR           = 2'h2;

    // ------------------------------------------------------------
    // gain lookup: factor in units of 1/16, 8 integer + 4 fraction bits
    // ------------------------------------------------------------
    localparam int         GAIN_CODE_W           = 6;
    localparam int         GAIN_FACTOR_W         = 12;
    localparam int         GAIN_MANT_W           = 3;
    localparam logic [11:0] GAIN_UNITY           = 12'h010;
    localparam int         NUM_CHANNELS          = 4;

    typedef logic [GAIN_CODE_W-1:0]   gain_code_t;
    typedef logic [GAIN_FACTOR_W-1:0] gain_factor_t;

    // channel 3 tracking state handed to the baseline tracker
    typedef struct packed {
        logic            active;
        logic [FTF_W-1:0] factor;
    } track_ctl_t;

endpackage

/* File: verif/tb_top.sv */
// self-checking bench for the tracking, identity and gain register block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    localparam logic [15:0] MAKER = 16'h5a17; // arbitrary value
    localparam logic [7:0]  PLOW  = 8'h62;    // arbitrary value
    localparam logic [7:0]  PHIGH = 8'h9b;    // arbitrary value
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [9:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic signed [15:0] ch3_processed_output;
    tracking_id_gain_pkg::gain_code_t   gain_code [4];
    tracking_id_gain_pkg::gain_factor_t gain_factor [4];
    tracking_id_gain_pkg::track_ctl_t   ch3_track_ctl;
    logic [33:0] note [$];
    logic [33:0] e;
    logic [7:0]  idv [4];
    int          err_count, n_tests, seed, i;

    tracking_id_gain_regs #(.MAKER_CODE(MAKER), .PART_LOW_4CH(PLOW),
        .PART_HIGH(PHIGH)) u_dut (
        .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .ch3_processed_output, .gain_code, .gain_factor, .ch3_track_ctl);

    task automatic check(input logic [31:0] seen, exp, input string nm);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // gain factor in sixteenths from the code
    function automatic logic [11:0] gexp(input int c);
        int b;
        b = 16 << (c / 8);
        return 12'((c % 8 == 0) ? b : b + b / 16 + (c % 8 - 1) * b / 8);
    endfunction

    // one bus transfer, answer stalled at random
    task automatic xfer(input bit rd, input logic [7:0] idx,
                        input logic [31:0] d, input logic [1:0] r);
        bit st;
        st = 1'($random(seed));
        note.push_back({r, d});
        s_axi_awaddr  <= {idx, 2'h0};
        s_axi_araddr  <= {idx, 2'h0};
        s_axi_wdata   <= d;
        s_axi_awvalid <= !rd;
        s_axi_wvalid  <= !rd;
        s_axi_arvalid <= rd;
        s_axi_bready  <= st;
        s_axi_rready  <= st;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_arvalid);
        while (!(rd ? s_axi_rvalid : s_axi_bvalid)) @(posedge aclk);
        if (!st) begin
            s_axi_bready <= 1;
            s_axi_rready <= 1;
            @(posedge aclk);
        end
        s_axi_bready <= 0;
        s_axi_rready <= 0;
        // let an edge pass so the next request never reassigns in this step
        @(posedge aclk);
    endtask

    // ----------------------------------------------------------------
    // scoreboard: oldest note against each bus answer
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (aresetn && s_axi_bvalid && s_axi_bready) begin
            e = note.pop_front();
            check(s_axi_bresp, e[33:32], "bresp");
        end
        if (aresetn && s_axi_rvalid && s_axi_rready) begin
            e = note.pop_front();
            check(s_axi_rresp, e[33:32], "rresp");
            check(s_axi_rdata, e[31:0], "rdata");
        end
    end

    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end

    // watchdog
    initial begin
        repeat (3000) @(posedge aclk);
        err_count++;
        complete_run;
    end

    initial begin
        seed = 4337;
        idv = '{MAKER[7:0], MAKER[15:8], PLOW, PHIGH};
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        ch3_processed_output = '0;
        gain_code = '{default: '0};
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        xfer(1, 8'h2b, 32'h1, 2'h0);
        // identity codes survive writes
        for (i = 0; i < 4; i++) begin
            xfer(0, 8'(252 + i), $random(seed), 2'h0);
            xfer(1, 8'(252 + i), 32'(idv[i]), 2'h0);
        end
        // every tracking code, gated by the output sign; drive on the
        // rising edge, look at the falling edge once the output settled
        for (i = 0; i < 4; i++) begin
            xfer(0, 8'h2b, 32'(i), 2'h0);
            xfer(1, 8'h2b, 32'(i), 2'h0);
            ch3_processed_output <= {1'b1, 15'($random(seed))};
            @(posedge aclk);
            @(negedge aclk);
            check(ch3_track_ctl, {1'b1, 2'(i)}, "track");
            @(posedge aclk);
            ch3_processed_output <= {1'b0, 15'($random(seed))};
            @(posedge aclk);
            @(negedge aclk);
            check(ch3_track_ctl, 32'h0, "track idle");
            @(posedge aclk);
        end
        // unmapped index
        xfer(0, 8'h10, 32'h5, tracking_id_gain_pkg::RESP_SLVERR);
        xfer(1, 8'h10, 32'h0, tracking_id_gain_pkg::RESP_SLVERR);
        // every gain code, spread over the channels
        for (i = 0; i < 64; i++) begin
            gain_code[i % 4] <= 6'(i);
            @(posedge aclk);
            @(negedge aclk);
            check(gain_factor[i % 4], gexp(i), "gain");
            @(posedge aclk);
        end
        complete_run;
    end
endmodule
`default_nettype wire

/* File: verif/tracking_id_gain_monitor.sv */
// assertion checker for the tracking, identity and gain register block
`timescale 1ns/100ps
`default_nettype none

module tracking_id_gain_monitor #(
    parameter int          DATA_W     = 16,
    parameter logic [15:0] MAKER_CODE = 16'h0000
) (
    input wire logic                     aclk,
    input wire logic                     aresetn,
    input wire logic                     s_axi_awvalid,
    input wire logic                     s_axi_awready,
    input wire logic                     s_axi_wvalid,
    input wire logic                     s_axi_wready,
    input wire logic                     s_axi_bvalid,
    input wire logic                     s_axi_bready,
    input wire logic                     s_axi_arvalid,
    input wire logic                     s_axi_arready,
    input wire logic [9:0]               s_axi_araddr,
    input wire logic                     s_axi_rvalid,
    input wire logic                     s_axi_rready,
    input wire logic [31:0]              s_axi_rdata,
    input wire logic signed [DATA_W-1:0] ch3_processed_output,
    input wire tracking_id_gain_pkg::gain_code_t   gain_code [4],
    input wire tracking_id_gain_pkg::gain_factor_t gain_factor [4],
    input wire tracking_id_gain_pkg::track_ctl_t   ch3_track_ctl
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // tracking control follows the sign of channel 3 output
    trk_neg_a:
        assert property (ch3_processed_output[DATA_W-1]
            |=> ch3_track_ctl.active)
        else $error("tracking idle after negative output");
    trk_idle_a:
        assert property (!ch3_processed_output[DATA_W-1]
            |=> ch3_track_ctl == 3'h0)
        else $error("tracking active after positive output");
    // bus answers and holding; write answer two edges after both taken
    wr_resp_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
            && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    b_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    r_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
            && $stable(s_axi_rdata)) else $error("read answer changed");
    rd_busy_a:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    rd_maker_a:
        assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2]
            == tracking_id_gain_pkg::IDX_MAKER_CODE_LOW |=> s_axi_rdata
            == {24'h0, MAKER_CODE[7:0]}) else $error("maker code wrong");
    gain_top_a:
        assert property (gain_code[3] == 6'h3f |=> gain_factor[3] == 12'he80)
        else $error("top gain factor wrong");

    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && !s_axi_rready);
    cover property (ch3_track_ctl.active);
endmodule

bind tracking_id_gain_regs tracking_id_gain_monitor #(
    .DATA_W(DATA_W), .MAKER_CODE(MAKER_CODE)) u_mon (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .ch3_processed_output, .gain_code, .gain_factor,
    .ch3_track_ctl);
`default_nettype wire
